// >>> hw/gauge_counter_value_judgment.sv
// value processing, peak tracking and tolerance judgment for four counters
//
// Notes on behaviour
// - four internal counters; counters 1,2 form pair 1, counters 3,4 pair 2
// - preset held plus mode press, or external pair signal, toggles pair
// - zero key sets the chosen internal counter's current value to zero
// - zeroing also sets max and min to the current value, spread zero
// - preset entry shows stored preset; mode shifts digit; preset key loads
// - select key during preset entry drops the edit and returns to counting
// - max, min and spread track every counter in every display mode
// - normal shows live value; max or min hold shows the stored extreme
// - spread mode shows max minus min, changing on new extremes and on zero, peak clear or preset
// - mode key outside entry steps display mode in a fixed cycle
// - zero in peak mode clears peaks of all counters sharing the unit
// - select key alternates upper and lower display on two-axis units
// - judgment form bit: zero three-step, one five-step
// - each internal counter keeps and uses its own four bounds
// - three-step: below b1 amber/out1, b1..b4 green/out3, above red/out5
// - five-step maps to amber, amber blink, green, red blink, red
// - three-step entry: bound one, then bound four, then back to counting
// - three-step error unless b1 <= b4; cancel restarts from bound one
// - five-step entry walks bounds one to four with their colours
// - five-step error unless strictly ascending or all four equal
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "gauge_defines.svh"

module gauge_counter_value_judgment #(
  parameter int unsigned BLINK_CYC = `BLINK_CYC
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [4*`VAL_W-1:0]  raw_counts,
  input  wire logic                 key_pset,
  input  wire logic                 key_mode,
  input  wire logic                 key_zero_a,
  input  wire logic                 key_zero_b,
  input  wire logic                 key_sel,
  input  wire logic                 key_limit,
  input  wire logic                 ext_pair_switch,
  output logic      [`VAL_W-1:0]    disp_upper,
  output logic      [`VAL_W-1:0]    disp_lower,
  output logic                      blink_upper,
  output logic                      blink_lower,
  output logic                      bank_two,
  output logic                      led_amber,
  output logic                      led_green,
  output logic                      led_red,
  output logic                      entry_error,
  output logic                      judge_out_upper_1,
  output logic                      judge_out_upper_2,
  output logic                      judge_out_upper_3,
  output logic                      judge_out_upper_4,
  output logic                      judge_out_upper_5,
  output logic                      judge_out_lower_1,
  output logic                      judge_out_lower_2,
  output logic                      judge_out_lower_3,
  output logic                      judge_out_lower_4,
  output logic                      judge_out_lower_5
);

  // internal counter index from pair and display row
  function automatic logic [1:0] cel_idx(input logic bank,
                                         input logic lower);
    cel_idx = {bank, lower};
  endfunction : cel_idx

  // step size of the edited decimal digit
  function automatic gauge_pkg::val_t pow10(input logic [2:0] d);
    case (d)
      3'd0:    pow10 = 32'h0000_0001;
      3'd1:    pow10 = 32'h0000_000A;
      3'd2:    pow10 = 32'h0000_0064;
      3'd3:    pow10 = 32'h0000_03E8;
      3'd4:    pow10 = 32'h0000_2710;
      3'd5:    pow10 = 32'h0001_86A0;
      3'd6:    pow10 = 32'h000F_4240;
      default: pow10 = 32'h0098_9680;
    endcase
  endfunction : pow10

  // one-hot judgment, bit 0 is output 1
  function automatic logic [4:0] judge(input gauge_pkg::val_t v,
                                       input gauge_pkg::val_t b1,
                                       input gauge_pkg::val_t b2,
                                       input gauge_pkg::val_t b3,
                                       input gauge_pkg::val_t b4,
                                       input logic five);
    if (v < b1)                judge = 5'b0_0001;
    else if (v > b4)           judge = 5'b1_0000;
    else if (!five)            judge = 5'b0_0100;
    else if (v < b2)           judge = 5'b0_0010;
    else if (v <= b3)          judge = 5'b0_0100;
    else                       judge = 5'b0_1000;
  endfunction : judge

  // bound set acceptance
  function automatic logic bounds_ok(input gauge_pkg::val_t b1,
                                     input gauge_pkg::val_t b2,
                                     input gauge_pkg::val_t b3,
                                     input gauge_pkg::val_t b4,
                                     input logic five);
    if (!five) bounds_ok = (b1 <= b4);
    else bounds_ok = ((b1 < b2) && (b2 < b3) && (b3 < b4)) ||
                     ((b1 == b2) && (b2 == b3) && (b3 == b4));
  endfunction : bounds_ok

  gauge_pkg::entry_t state_r;
  gauge_pkg::dmode_t dmode_r [`NUM_CEL];
  gauge_pkg::val_t   off_r   [`NUM_CEL];
  gauge_pkg::val_t   cur_r   [`NUM_CEL];
  gauge_pkg::val_t   max_r   [`NUM_CEL];
  gauge_pkg::val_t   min_r   [`NUM_CEL];
  gauge_pkg::val_t   spr_r   [`NUM_CEL];
  gauge_pkg::val_t   dval_r  [`NUM_CEL];
  gauge_pkg::val_t   pre_r   [`NUM_CEL];
  gauge_pkg::val_t   bnd_r   [`NUM_CEL][`NUM_BND];
  gauge_pkg::val_t   pend_r  [`NUM_BND];
  gauge_pkg::val_t   edit_r;
  gauge_pkg::val_t   cand    [`NUM_BND];
  logic [1:0]         ctrl_r;
  logic [11:0]        unit_r;
  logic [`KEY_W-1:0]  k1_r, k2_r, k3_r, kst_r, press_r, rel_r;
  logic [`KEY_W-1:0]  agreed;
  logic               bank_r, sel_lower_r, used_r, err_r, phase_r;
  logic [2:0]         digit_r;
  logic [1:0]         tidx_r, ux, lx, sx, tz;
  logic [31:0]        bcnt_r;
  logic [`NUM_CEL-1:0] zero_req, clr_req, pre_req;
  logic               five, two_axis, ztarget, last_bnd;
  logic [4:0]         jup, jlo, jsel;

  assign five     = ctrl_r[`CTRL_FIVE_BIT];
  assign two_axis = ctrl_r[`CTRL_TWO_BIT];
  assign ux       = cel_idx(bank_r, 1'b0);
  assign lx       = cel_idx(bank_r, 1'b1);
  assign sx       = sel_lower_r ? lx : ux;

  // key synchroniser: a change counts once stages two and three agree
  assign agreed = (k2_r & k3_r) | (kst_r & (k2_r ^ k3_r));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      k1_r    <= '0;
      k2_r    <= '0;
      k3_r    <= '0;
      kst_r   <= '0;
      press_r <= '0;
      rel_r   <= '0;
    end else begin
      k1_r    <= {ext_pair_switch, key_limit, key_sel, key_zero_b,
                  key_zero_a, key_mode, key_pset};
      k2_r    <= k1_r;
      k3_r    <= k2_r;
      kst_r   <= agreed;
      press_r <= agreed & ~kst_r;
      rel_r   <= ~agreed & kst_r;
    end
  end

  // apb slave: registered answer, pready one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
      ctrl_r  <= `CTRL_RST;
      unit_r  <= `UNIT_RST;
    end else begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= '0;
      // writes land on the edge that completes the access
      if (psel && penable && pready && pwrite && paddr == `OFF_CTRL)
        ctrl_r <= pwdata[1:0];
      else if (psel && penable && pready && pwrite && paddr == `OFF_UNIT)
        unit_r <= pwdata[11:0];
      if (psel && !penable && !pready) begin
        case (paddr[7:4])
          4'h0: begin
            case (paddr)
              `OFF_CTRL:   prdata <= {30'h0000_0000, ctrl_r};
              `OFF_UNIT:   prdata <= {20'h0_0000, unit_r};
              `OFF_STATUS: prdata <= {24'h00_0000, err_r, tidx_r,
                                      state_r, phase_r, sel_lower_r,
                                      bank_r};
              `OFF_EDIT:   prdata <= edit_r;
              default:     pslverr <= 1'b1;
            endcase
          end
          `GRP_VALUE: prdata <= cur_r[paddr[3:2]];
          `GRP_MAX:   prdata <= max_r[paddr[3:2]];
          `GRP_MIN:   prdata <= min_r[paddr[3:2]];
          default:    pslverr <= 1'b1;
        endcase
        if (paddr[1:0] != 2'b00)
          pslverr <= 1'b1;
      end
    end
  end

  // zero key actions: live zero in normal mode, peak clear otherwise
  always_comb begin
    zero_req = '0;
    clr_req  = '0;
    pre_req  = '0;
    ztarget  = 1'b0;
    tz       = ux;
    if (state_r == gauge_pkg::ST_COUNT) begin
      if (press_r[`KEY_ZA]) begin
        ztarget = 1'b1;
        tz      = ux;
      end else if (press_r[`KEY_ZB] && two_axis) begin
        ztarget = 1'b1;
        tz      = lx;
      end
    end
    if (ztarget) begin
      if (dmode_r[tz] == gauge_pkg::DM_NORMAL)
        zero_req[tz] = 1'b1;
      else
        for (int j = 0; j < `NUM_CEL; j++)
          if (unit_r[j*`UNIT_W +: `UNIT_W] ==
              unit_r[tz*`UNIT_W +: `UNIT_W])
            clr_req[j] = 1'b1;
    end
    if (state_r == gauge_pkg::ST_PRESET && press_r[`KEY_PSET])
      pre_req[sx] = 1'b1;
  end

  // per counter value, offset and peak tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `NUM_CEL; i++) begin
        off_r[i]  <= '0;
        cur_r[i]  <= '0;
        max_r[i]  <= '0;
        min_r[i]  <= '0;
        spr_r[i]  <= '0;
        dval_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `NUM_CEL; i++) begin
        spr_r[i] <= max_r[i] - min_r[i];
        if (zero_req[i]) begin
          off_r[i] <= -$signed(raw_counts[i*`VAL_W +: `VAL_W]);
          cur_r[i] <= '0;
          max_r[i] <= '0;
          min_r[i] <= '0;
        end else if (pre_req[i]) begin
          off_r[i] <= edit_r - $signed(raw_counts[i*`VAL_W +: `VAL_W]);
          cur_r[i] <= edit_r;
          max_r[i] <= edit_r;
          min_r[i] <= edit_r;
        end else begin
          cur_r[i] <= $signed(raw_counts[i*`VAL_W +: `VAL_W]) + off_r[i];
          if (clr_req[i]) begin
            max_r[i] <= cur_r[i];
            min_r[i] <= cur_r[i];
          end else begin
            if (cur_r[i] > max_r[i]) max_r[i] <= cur_r[i];
            if (cur_r[i] < min_r[i]) min_r[i] <= cur_r[i];
          end
        end
        case (dmode_r[i])
          gauge_pkg::DM_MAX:    dval_r[i] <= max_r[i];
          gauge_pkg::DM_MIN:    dval_r[i] <= min_r[i];
          gauge_pkg::DM_SPREAD: dval_r[i] <= spr_r[i];
          default:              dval_r[i] <= cur_r[i];
        endcase
      end
    end
  end

  // displayed pair: combo keys or external line, both may coincide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bank_r <= 1'b0;
    else
      bank_r <= bank_r ^ press_r[`KEY_PAIR] ^
                (state_r == gauge_pkg::ST_COUNT && press_r[`KEY_MODE] &&
                 kst_r[`KEY_PSET]);
  end

  // candidate bound set, current edit standing in for the open bound
  always_comb begin
    for (int k = 0; k < `NUM_BND; k++)
      cand[k] = (tidx_r == k[1:0]) ? edit_r : pend_r[k];
    if (!five) begin
      cand[1] = cand[0];
      cand[2] = cand[3];
    end
  end
  assign last_bnd = (tidx_r == 2'd3);

  // key driven entry state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= gauge_pkg::ST_COUNT;
      sel_lower_r <= 1'b0;
      used_r      <= 1'b0;
      err_r       <= 1'b0;
      digit_r     <= `DIGIT_MSB;
      tidx_r      <= 2'd0;
      edit_r      <= '0;
      for (int i = 0; i < `NUM_CEL; i++) begin
        dmode_r[i] <= gauge_pkg::DM_NORMAL;
        pre_r[i]   <= '0;
        pend_r[i]  <= '0;
        for (int k = 0; k < `NUM_BND; k++)
          bnd_r[i][k] <= '0;
      end
    end else begin
      case (state_r)
        gauge_pkg::ST_COUNT: begin
          if (press_r[`KEY_PSET])
            used_r <= 1'b0;
          if (press_r[`KEY_MODE] && kst_r[`KEY_PSET])
            used_r <= 1'b1;
          else if (press_r[`KEY_MODE])
            dmode_r[sx] <= gauge_pkg::dmode_t'(dmode_r[sx] + 2'd1);
          if (press_r[`KEY_SEL] && two_axis)
            sel_lower_r <= ~sel_lower_r;
          if (rel_r[`KEY_PSET] && !used_r) begin
            state_r <= gauge_pkg::ST_PRESET;
            edit_r  <= pre_r[sx];
            digit_r <= `DIGIT_MSB;
          end else if (press_r[`KEY_LIMIT]) begin
            state_r <= gauge_pkg::ST_TOL;
            tidx_r  <= 2'd0;
            err_r   <= 1'b0;
            edit_r  <= bnd_r[sx][0];
            digit_r <= `DIGIT_MSB;
            for (int k = 0; k < `NUM_BND; k++)
              pend_r[k] <= bnd_r[sx][k];
          end
        end
        gauge_pkg::ST_PRESET: begin
          if (press_r[`KEY_SEL])
            state_r <= gauge_pkg::ST_COUNT;
          else if (press_r[`KEY_PSET]) begin
            pre_r[sx] <= edit_r;
            used_r    <= 1'b1;
            state_r   <= gauge_pkg::ST_COUNT;
          end
        end
        gauge_pkg::ST_TOL: begin
          if (press_r[`KEY_SEL]) begin
            tidx_r <= 2'd0;
            err_r  <= 1'b0;
            edit_r <= pend_r[0];
          end else if (press_r[`KEY_LIMIT]) begin
            pend_r[tidx_r] <= edit_r;
            if (!last_bnd) begin
              tidx_r <= five ? tidx_r + 2'd1 : 2'd3;
              edit_r <= five ? pend_r[tidx_r + 2'd1] : pend_r[3];
            end else if (bounds_ok(cand[0], cand[1], cand[2], cand[3],
                                   five)) begin
              for (int k = 0; k < `NUM_BND; k++)
                bnd_r[sx][k] <= cand[k];
              state_r <= gauge_pkg::ST_COUNT;
            end else
              err_r <= 1'b1;
          end
        end
        default: state_r <= gauge_pkg::ST_COUNT;
      endcase
      // digit editing shared by preset and bound entry
      if (state_r != gauge_pkg::ST_COUNT && !press_r[`KEY_SEL]) begin
        if (press_r[`KEY_MODE])
          digit_r <= (digit_r == `DIGIT_LSB) ? `DIGIT_MSB
                                              : digit_r - 3'd1;
        if (press_r[`KEY_ZA])
          edit_r <= edit_r + pow10(digit_r);
        else if (press_r[`KEY_ZB])
          edit_r <= edit_r - pow10(digit_r);
      end
    end
  end

  // blink phase divider; the count is long, so it is a parameter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_r  <= '0;
      phase_r <= 1'b0;
    end else if (bcnt_r == BLINK_CYC - 32'd1) begin
      bcnt_r  <= '0;
      phase_r <= ~phase_r;
    end else
      bcnt_r <= bcnt_r + 32'd1;
  end

  assign jup  = judge(dval_r[ux], bnd_r[ux][0], bnd_r[ux][1],
                      bnd_r[ux][2], bnd_r[ux][3], five);
  assign jlo  = judge(dval_r[lx], bnd_r[lx][0], bnd_r[lx][1],
                      bnd_r[lx][2], bnd_r[lx][3], five);
  assign jsel = sel_lower_r ? jlo : jup;

  // registered display, judgment and indicator outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_upper  <= '0;
      disp_lower  <= '0;
      blink_upper <= 1'b0;
      blink_lower <= 1'b0;
      bank_two    <= 1'b0;
      led_amber   <= 1'b0;
      led_green   <= 1'b0;
      led_red     <= 1'b0;
      entry_error <= 1'b0;
      {judge_out_upper_5, judge_out_upper_4, judge_out_upper_3,
       judge_out_upper_2, judge_out_upper_1} <= 5'b0_0100;
      {judge_out_lower_5, judge_out_lower_4, judge_out_lower_3,
       judge_out_lower_2, judge_out_lower_1} <= 5'b0_0100;
    end else begin
      // editing replaces the chosen row so the user sees the value
      disp_upper <= (state_r != gauge_pkg::ST_COUNT && !sel_lower_r)
                    ? edit_r : dval_r[ux];
      disp_lower <= (state_r != gauge_pkg::ST_COUNT && sel_lower_r)
                    ? edit_r : dval_r[lx];
      blink_upper <= two_axis & ~sel_lower_r & phase_r;
      blink_lower <= two_axis & sel_lower_r & phase_r;
      bank_two    <= bank_r;
      entry_error <= err_r;
      {judge_out_upper_5, judge_out_upper_4, judge_out_upper_3,
       judge_out_upper_2, judge_out_upper_1} <= jup;
      {judge_out_lower_5, judge_out_lower_4, judge_out_lower_3,
       judge_out_lower_2, judge_out_lower_1} <= jlo;
      if (state_r == gauge_pkg::ST_TOL) begin
        // colour of the bound being entered
        led_green <= 1'b0;
        led_amber <= (tidx_r == 2'd0) | ((tidx_r == 2'd1) & phase_r);
        led_red   <= (tidx_r == 2'd3) | ((tidx_r == 2'd2) & phase_r);
      end else begin
        led_amber <= jsel[0] | (jsel[1] & phase_r);
        led_green <= jsel[2];
        led_red   <= jsel[4] | (jsel[3] & phase_r);
      end
    end
  end

endmodule : gauge_counter_value_judgment

// >>> hw/gauge_defines.svh
// constants for the gauge counter value and judgment block
`ifndef GAUGE_DEFINES_SVH
`define GAUGE_DEFINES_SVH

// data widths and counts
`define VAL_W          32
`define NUM_CEL        4
`define NUM_BND        4
`define UNIT_W         3
`define DIGIT_MSB      3'd7
`define DIGIT_LSB      3'd0

// register byte offsets
`define OFF_CTRL       8'h00
`define OFF_UNIT       8'h04
`define OFF_STATUS     8'h08
`define OFF_EDIT       8'h0C
`define GRP_VALUE      4'h1
`define GRP_MAX        4'h2
`define GRP_MIN        4'h3

// control fields and reset values
`define CTRL_FIVE_BIT  0
`define CTRL_TWO_BIT   1
`define CTRL_RST       2'b10
`define UNIT_RST       12'h208

// key vector positions
`define KEY_W          7
`define KEY_PSET       0
`define KEY_MODE       1
`define KEY_ZA         2
`define KEY_ZB         3
`define KEY_SEL        4
`define KEY_LIMIT      5
`define KEY_PAIR       6

// blink timing at the 50 MHz pclk
`define CLK_HZ         50000000
`define BLINK_MS       250
`define BLINK_CYC      ((`CLK_HZ / 1000) * `BLINK_MS)

`endif

// >>> hw/gauge_pkg.sv
// types shared by the gauge counter value and judgment block
package gauge_pkg;

  typedef enum logic [1:0] {
    ST_COUNT,
    ST_PRESET,
    ST_TOL
  } entry_t;

  typedef enum logic [1:0] {
    DM_NORMAL,
    DM_MAX,
    DM_MIN,
    DM_SPREAD
  } dmode_t;

  typedef logic signed [31:0] val_t;

endpackage : gauge_pkg

// >>> bench/gauge_judge_monitor.sv
// checker for judgment outputs, pair switching and bus timing
`timescale 1ns/1ns
module gauge_judge_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        ext_pair_switch,
  input wire logic        bank_two,
  input wire logic        led_amber,
  input wire logic        led_red,
  input wire logic [4:0]  ju,
  input wire logic [4:0]  jl
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  // the pin passes a three-stage filter before it acts
  sequence pair_rise_s;
    $rose(ext_pair_switch);
  endsequence
  upper_onehot_a:
    assert property ($onehot(ju)) else $error("upper judgment not one-hot");
  lower_onehot_a:
    assert property ($onehot(jl)) else $error("lower judgment not one-hot");
  led_excl_a:
    assert property (!(led_amber && led_red)) else $error("amber with red");
  pair_toggle_a:
    assert property (pair_rise_s |-> ##[2:10] $changed(bank_two))
      else $error("pair switch ignored");
  setup_ready_a:
    assert property (setup_s |=> pready) else $error("no ready after setup");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("ready held too long");
  err_ready_a:
    assert property (pslverr |-> pready) else $error("error without ready");
  rdata_idle_a:
    assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside access");
endmodule : gauge_judge_monitor
bind gauge_counter_value_judgment gauge_judge_monitor mon_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .ext_pair_switch(ext_pair_switch), .bank_two(bank_two),
  .led_amber(led_amber), .led_red(led_red),
  .ju({judge_out_upper_5, judge_out_upper_4, judge_out_upper_3,
       judge_out_upper_2, judge_out_upper_1}),
  .jl({judge_out_lower_5, judge_out_lower_4, judge_out_lower_3,
       judge_out_lower_2, judge_out_lower_1}));

// >>> bench/panel_keys.sv
// front panel model: key and pair-switch levels
`timescale 1ns/1ns
`include "gauge_defines.svh"
module panel_keys (
  input  wire logic pclk,
  output logic      key_pset,
  output logic      key_mode,
  output logic      key_zero_a,
  output logic      key_zero_b,
  output logic      key_sel,
  output logic      key_limit,
  output logic      ext_pair_switch
);
  // held long enough to pass the key filter and settle
  localparam int HOLD = 8;
  logic [`KEY_W-1:0] k = '0;
  assign {ext_pair_switch, key_limit, key_sel, key_zero_b, key_zero_a,
          key_mode, key_pset} = k;
  task automatic set(input int i, input logic v);
    @(posedge pclk);
    k[i] <= v;
    repeat (HOLD) @(posedge pclk);
  endtask : set
  task automatic press(input int i);
    set(i, 1'b1);
    set(i, 1'b0);
  endtask : press
endmodule : panel_keys

// >>> bench/gauge_counter_value_judgment_tb.sv
// self-checking bench for the gauge value and judgment block
`timescale 1ns/1ns
`include "gauge_defines.svh"
module gauge_counter_value_judgment_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, disp_upper, disp_lower;
  logic        key_pset, key_mode, key_zero_a, key_zero_b, key_sel;
  logic        key_limit, ext_pair_switch, bank_two, led_green;
  wire  [4:0]  ju, jl;
  gauge_pkg::val_t raw [4];
  int          offs[4], mx[4], mn[4], md[4], bk, err_total, samples_checked;
  int          bd[4];
  gauge_counter_value_judgment #(.BLINK_CYC(4))
    gauge_counter_value_judgment_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .raw_counts({raw[3], raw[2], raw[1], raw[0]}), .key_pset(key_pset),
    .key_mode(key_mode), .key_zero_a(key_zero_a), .key_zero_b(key_zero_b),
    .key_sel(key_sel), .key_limit(key_limit),
    .ext_pair_switch(ext_pair_switch), .disp_upper(disp_upper),
    .disp_lower(disp_lower), .blink_upper(), .blink_lower(),
    .bank_two(bank_two), .led_amber(), .led_green(led_green), .led_red(),
    .entry_error(), .judge_out_upper_1(ju[0]), .judge_out_upper_2(ju[1]),
    .judge_out_upper_3(ju[2]), .judge_out_upper_4(ju[3]),
    .judge_out_upper_5(ju[4]), .judge_out_lower_1(jl[0]),
    .judge_out_lower_2(jl[1]), .judge_out_lower_3(jl[2]),
    .judge_out_lower_4(jl[3]), .judge_out_lower_5(jl[4]));
  panel_keys panel_inst (
    .pclk(pclk), .key_pset(key_pset), .key_mode(key_mode),
    .key_zero_a(key_zero_a), .key_zero_b(key_zero_b), .key_sel(key_sel),
    .key_limit(key_limit), .ext_pair_switch(ext_pair_switch));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      err_total++;
      $display("FAIL at %0t: got %h want %h", $time, s, x);
    end
  endtask : chk
  task automatic close_out();
    $display("checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  // one transfer; holds the request until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      $display("FAIL at %0t: no bus answer", $time);
      close_out();
    end
  endtask : apb
  function automatic int cur(input int i);
    return raw[i] - offs[i];
  endfunction : cur
  function automatic int dv(input int i);
    case (md[i])
      0: return cur(i);
      1: return mx[i];
      2: return mn[i];
      default: return mx[i] - mn[i];
    endcase
  endfunction : dv
  // judgment from the rules; bd holds the first counter's bounds
  function automatic logic [4:0] jd(input int v, input int i);
    int b[4];
    b = bd;
    if (i != 0) b = '{default: 0};
    if (v < b[0]) return 5'h01;
    if (v > b[3]) return 5'h10;
    if (v < b[1]) return 5'h02;
    return v <= b[2] ? 5'h04 : 5'h08;
  endfunction : jd
  task automatic track(input int i, input logic clr);
    mx[i] = (clr || cur(i) > mx[i]) ? cur(i) : mx[i];
    mn[i] = (clr || cur(i) < mn[i]) ? cur(i) : mn[i];
  endtask : track
  task automatic check();
    int u, l;
    u = dv(2 * bk);
    l = dv(2 * bk + 1);
    chk(disp_upper, u);
    chk(disp_lower, l);
    chk(ju, jd(u, 2 * bk));
    chk(jl, jd(l, 1));
    chk(led_green, jd(u, 2 * bk) == 5'h04);
  endtask : check
  task automatic setraw(input int i, input int v);
    @(posedge pclk);
    raw[i] <= v;
    repeat (6) @(posedge pclk);
    track(i, 1'b0);
    check();
  endtask : setraw
  task automatic key(input int k);
    panel_inst.press(k);
    check();
  endtask : key
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    raw = '{default: 0};
    void'($urandom(32'h0000_4a99));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, '0);
    chk(rd, 32'h0000_0002);
    apb(1'b0, 8'h04, '0);
    chk(rd, 32'h0000_0208);
    apb(1'b0, 8'h40, '0);
    chk(e, 1'b1);
    $display("test registers done");
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, 8'h00, 32'(2 + f));
      repeat (6) begin
        setraw($urandom_range(3), int'($urandom_range(2000)) - 1000);
        apb(1'b0, 8'h10, '0);
        chk(rd, cur(0));
      end
    end
    $display("test random counts done");
    bk = 1;
    key(`KEY_PAIR);
    panel_inst.set(`KEY_PSET, 1'b1);
    panel_inst.press(`KEY_MODE);
    bk = 0;
    key(`KEY_PSET);
    $display("test pair switch done");
    offs[0] = raw[0];
    mx[0] = 0;
    mn[0] = 0;
    key(`KEY_ZA);
    apb(1'b0, 8'h20, '0);
    chk(rd, 0);
    apb(1'b0, 8'h30, '0);
    chk(rd, 0);
    $display("test zero done");
    md[0] = 1;
    key(`KEY_MODE);
    setraw(0, raw[0] + 50);
    setraw(0, raw[0] - 80);
    md[0] = 2;
    key(`KEY_MODE);
    md[0] = 3;
    key(`KEY_MODE);
    track(0, 1'b1);
    track(2, 1'b1);
    key(`KEY_ZA);
    apb(1'b0, 8'h28, '0);
    chk(rd, cur(2));
    md[0] = 0;
    key(`KEY_MODE);
    $display("test peak modes done");
    panel_inst.press(`KEY_PSET);
    chk(disp_upper, 0);
    panel_inst.press(`KEY_ZA);
    panel_inst.press(`KEY_MODE);
    panel_inst.press(`KEY_ZA);
    chk(disp_upper, 11000000);
    offs[0] = raw[0] - 11000000;
    track(0, 1'b1);
    key(`KEY_PSET);
    panel_inst.press(`KEY_PSET);
    panel_inst.press(`KEY_ZA);
    key(`KEY_SEL);
    $display("test preset done");
    // five-step bounds on the first counter, a rejected set first
    panel_inst.press(`KEY_LIMIT);
    panel_inst.press(`KEY_ZA);
    repeat (4) panel_inst.press(`KEY_LIMIT);
    apb(1'b0, 8'h08, '0);
    chk(rd[7:3], 5'b1_1110);
    panel_inst.press(`KEY_SEL);
    panel_inst.press(`KEY_ZB);
    repeat (7) panel_inst.press(`KEY_MODE);
    panel_inst.press(`KEY_ZB);
    repeat (2) panel_inst.press(`KEY_LIMIT);
    panel_inst.press(`KEY_ZA);
    panel_inst.press(`KEY_LIMIT);
    panel_inst.press(`KEY_ZA);
    panel_inst.press(`KEY_ZA);
    bd = '{-1, 0, 1, 2};
    key(`KEY_LIMIT);
    for (int v = -2; v < 4; v++)
      setraw(0, offs[0] + v);
    $display("test bounds done");
    close_out();
  end
endmodule : gauge_counter_value_judgment_tb
